// ### tvf_framer.sv
// tvf_framer: watches telecommand reception and frames verification reports
// assumes the telecommand receiver and time source run on ref_clk
// Behaviour
// - success report for valid command with acknowledge set
// - invalid command yields failure report instead
// - 14-bit report counter, incremented per report
// - success data field 14, packet 20 bytes
// - first payload word copies command identifier
// - success second word copies sequence control
// - failure second word copies sequence control
// - failure data field 22, packet 28 bytes
// - failure code follows, high byte first
// - then type, subtype, two 16-bit parameters
// - incomplete after 2 s: code 1
// - CRC differs: code 2, received then computed
// - wrong process id or category: code 3
// - codes 5 busy, 6 payload, 4 invalid
// - six-byte elapsed time captured at generation
// - category 1, service 1 subtypes 1/2
// - sequence top bits one, counter wraps 16383
// - length field holds data field minus one
`timescale 1ns/1ps
module tvf_framer #(
  parameter int unsigned TIMEOUT_CYC = tvf_pkg::TC_TIMEOUT_CYC
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tc_start,
  input wire logic tc_byte,
  input wire logic tc_hdr_valid,
  input wire logic [15:0] tc_packet_id,
  input wire logic [15:0] tc_seq_ctrl,
  input wire logic [15:0] tc_expected_bytes,
  input wire logic [7:0] tc_type,
  input wire logic [7:0] tc_subtype,
  input wire logic tc_ack,
  input wire logic tc_end,
  input wire logic [15:0] tc_crc_rx,
  input wire logic [15:0] tc_crc_calc,
  input wire logic tc_wrong_id,
  input wire logic tc_invalid,
  input wire logic tc_not_exec,
  input wire logic tc_bad_payload,
  input wire logic [47:0] spacecraft_elapsed_time,
  output logic [7:0] tm_data,
  output logic tm_last,
  output logic tm_valid,
  input wire logic tm_ready,
  output logic tc_receiving,
  output logic report_overrun
);
  // receiver side state
  tvf_pkg::tvf_rx_state_t rx_state;
  tvf_pkg::tvf_rx_state_t next_rx_state;
  logic [31:0] rx_timer;
  logic [31:0] next_rx_timer;
  logic [15:0] rx_bytes;
  logic [15:0] next_rx_bytes;
  logic [15:0] hd_id;
  logic [15:0] next_hd_id;
  logic [15:0] hd_seq;
  logic [15:0] next_hd_seq;
  logic [15:0] hd_expected;
  logic [15:0] next_hd_expected;
  logic [7:0] hd_type;
  logic [7:0] next_hd_type;
  logic [7:0] hd_sub;
  logic [7:0] next_hd_sub;
  logic hd_ack;
  logic next_hd_ack;
  logic next_tc_receiving;
  logic next_report_overrun;

  // pending report request
  logic rq_pend;
  logic next_rq_pend;
  logic rq_fail;
  logic next_rq_fail;
  logic [15:0] rq_code;
  logic [15:0] next_rq_code;
  logic [15:0] rq_p3;
  logic [15:0] next_rq_p3;
  logic [15:0] rq_p4;
  logic [15:0] next_rq_p4;
  logic [15:0] rq_id;
  logic [15:0] next_rq_id;
  logic [15:0] rq_seq;
  logic [15:0] next_rq_seq;
  logic [7:0] rq_type;
  logic [7:0] next_rq_type;
  logic [7:0] rq_sub;
  logic [7:0] next_rq_sub;

  // serializer state
  tvf_pkg::tvf_tx_state_t tx_state;
  tvf_pkg::tvf_tx_state_t next_tx_state;
  logic [4:0] tx_idx;
  logic [4:0] next_tx_idx;
  logic [13:0] seq_cnt;
  logic [13:0] next_seq_cnt;
  logic [47:0] tx_time;
  logic [47:0] next_tx_time;
  logic tx_fail;
  logic next_tx_fail;
  logic [15:0] tx_code;
  logic [15:0] next_tx_code;
  logic [15:0] tx_p3;
  logic [15:0] next_tx_p3;
  logic [15:0] tx_p4;
  logic [15:0] next_tx_p4;
  logic [15:0] tx_id;
  logic [15:0] next_tx_id;
  logic [15:0] tx_seq;
  logic [15:0] next_tx_seq;
  logic [7:0] tx_type;
  logic [7:0] next_tx_type;
  logic [7:0] tx_sub;
  logic [7:0] next_tx_sub;

  logic take;
  logic [7:0] cur_byte;
  logic [4:0] cur_len;
  logic fifo_in_valid;
  logic fifo_in_ready;

  assign take = (tx_state == tvf_pkg::TVF_TX_IDLE) && rq_pend;

  // receiver: timeout watch, header capture and verdict in priority order
  always_comb
  begin
    next_rx_state = rx_state;
    next_rx_timer = rx_timer;
    next_rx_bytes = rx_bytes;
    next_hd_id = hd_id;
    next_hd_seq = hd_seq;
    next_hd_expected = hd_expected;
    next_hd_type = hd_type;
    next_hd_sub = hd_sub;
    next_hd_ack = hd_ack;
    next_rq_pend = rq_pend && !take;
    next_rq_fail = rq_fail;
    next_rq_code = rq_code;
    next_rq_p3 = rq_p3;
    next_rq_p4 = rq_p4;
    next_rq_id = rq_id;
    next_rq_seq = rq_seq;
    next_rq_type = rq_type;
    next_rq_sub = rq_sub;
    next_report_overrun = 1'b0;
    case (rx_state)
      tvf_pkg::TVF_RX_IDLE:
      begin
        if (tc_start)
        begin
          next_rx_state = tvf_pkg::TVF_RX_RECV;
          next_rx_timer = '0;
          next_rx_bytes = '0;
        end
      end
      tvf_pkg::TVF_RX_RECV:
      begin
        next_rx_timer = rx_timer + 32'h0000_0001;
        if (tc_byte)
        begin
          next_rx_bytes = rx_bytes + 16'h0001;
        end
        if (tc_hdr_valid)
        begin
          next_hd_id = tc_packet_id;
          next_hd_seq = tc_seq_ctrl;
          next_hd_expected = tc_expected_bytes;
          next_hd_type = tc_type;
          next_hd_sub = tc_subtype;
          next_hd_ack = tc_ack;
        end
        if (tc_end || rx_timer == TIMEOUT_CYC - 1)
        begin
          next_rx_state = tvf_pkg::TVF_RX_IDLE;
          next_rq_id = tc_hdr_valid ? tc_packet_id : hd_id;
          next_rq_seq = tc_hdr_valid ? tc_seq_ctrl : hd_seq;
          next_rq_type = tc_hdr_valid ? tc_type : hd_type;
          next_rq_sub = tc_hdr_valid ? tc_subtype : hd_sub;
          next_rq_fail = 1'b1;
          next_rq_p3 = '0;
          next_rq_p4 = '0;
          next_report_overrun = rq_pend && !take;
          next_rq_pend = 1'b1;
          if (!tc_end)
          begin
            next_rq_code = tvf_pkg::FAIL_INCOMPLETE_TIMEOUT;
            next_rq_p3 = hd_expected;
            next_rq_p4 = next_rx_bytes;
          end
          else if (tc_crc_rx != tc_crc_calc)
          begin
            next_rq_code = tvf_pkg::FAIL_CRC_MISMATCH;
            next_rq_p3 = tc_crc_rx;
            next_rq_p4 = tc_crc_calc;
          end
          else if (tc_wrong_id)
          begin
            next_rq_code = tvf_pkg::FAIL_WRONG_PROCESS_ID;
          end
          else if (tc_invalid)
          begin
            next_rq_code = tvf_pkg::FAIL_INVALID_COMMAND;
          end
          else if (tc_not_exec)
          begin
            next_rq_code = tvf_pkg::FAIL_NOT_EXECUTABLE_NOW;
          end
          else if (tc_bad_payload)
          begin
            next_rq_code = tvf_pkg::FAIL_INCONSISTENT_PAYLOAD;
          end
          else
          begin
            next_rq_fail = 1'b0;
            next_rq_code = '0;
            next_rq_pend = (tc_hdr_valid ? tc_ack : hd_ack) || (rq_pend && !take);
            next_report_overrun = (tc_hdr_valid ? tc_ack : hd_ack) && rq_pend && !take;
          end
        end
      end
      default:
      begin
        next_rx_state = tvf_pkg::TVF_RX_IDLE;
      end
    endcase
    next_tc_receiving = (next_rx_state == tvf_pkg::TVF_RX_RECV);
  end

  // receiver registers
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rx_state <= tvf_pkg::TVF_RX_IDLE;
      rx_timer <= '0;
      rx_bytes <= '0;
      hd_id <= '0;
      hd_seq <= '0;
      hd_expected <= '0;
      hd_type <= '0;
      hd_sub <= '0;
      hd_ack <= 1'b0;
      rq_pend <= 1'b0;
      rq_fail <= 1'b0;
      rq_code <= '0;
      rq_p3 <= '0;
      rq_p4 <= '0;
      rq_id <= '0;
      rq_seq <= '0;
      rq_type <= '0;
      rq_sub <= '0;
      tc_receiving <= 1'b0;
      report_overrun <= 1'b0;
    end
    else if (ce)
    begin
      rx_state <= next_rx_state;
      rx_timer <= next_rx_timer;
      rx_bytes <= next_rx_bytes;
      hd_id <= next_hd_id;
      hd_seq <= next_hd_seq;
      hd_expected <= next_hd_expected;
      hd_type <= next_hd_type;
      hd_sub <= next_hd_sub;
      hd_ack <= next_hd_ack;
      rq_pend <= next_rq_pend;
      rq_fail <= next_rq_fail;
      rq_code <= next_rq_code;
      rq_p3 <= next_rq_p3;
      rq_p4 <= next_rq_p4;
      rq_id <= next_rq_id;
      rq_seq <= next_rq_seq;
      rq_type <= next_rq_type;
      rq_sub <= next_rq_sub;
      tc_receiving <= next_tc_receiving;
      report_overrun <= next_report_overrun;
    end
  end

  // byte selection for the report being sent
  always_comb
  begin
    cur_len = tx_fail ? tvf_pkg::PKT_LEN_FAILURE : tvf_pkg::PKT_LEN_SUCCESS;
    cur_byte = tvf_pkg::PAD_BYTE;
    case (tx_idx)
      5'h00: cur_byte = tvf_pkg::HDR_BYTE0;
      5'h01: cur_byte = {tvf_pkg::APID_LOW, tvf_pkg::CAT_ACK};
      tvf_pkg::POS_SEQ_HI: cur_byte = {tvf_pkg::SEQ_FLAGS, seq_cnt[13:8]};
      tvf_pkg::POS_SEQ_LO: cur_byte = seq_cnt[7:0];
      tvf_pkg::POS_LEN_HI: cur_byte = tvf_pkg::LEN_HIGH;
      tvf_pkg::POS_LEN_LO: cur_byte = (tx_fail ? tvf_pkg::DF_LEN_FAILURE : tvf_pkg::DF_LEN_SUCCESS) - 8'h01;
      tvf_pkg::POS_PUS: cur_byte = tvf_pkg::PUS_BYTE;
      tvf_pkg::POS_SVC: cur_byte = tvf_pkg::SVC_VERIF;
      tvf_pkg::POS_SUB: cur_byte = tx_fail ? tvf_pkg::SUB_FAILURE : tvf_pkg::SUB_SUCCESS;
      tvf_pkg::POS_PAD: cur_byte = tvf_pkg::PAD_BYTE;
      tvf_pkg::POS_ID_HI: cur_byte = tx_id[15:8];
      tvf_pkg::POS_ID_LO: cur_byte = tx_id[7:0];
      tvf_pkg::POS_SC_HI: cur_byte = tx_seq[15:8];
      tvf_pkg::POS_SC_LO: cur_byte = tx_seq[7:0];
      tvf_pkg::POS_CODE_HI: cur_byte = tx_code[15:8];
      tvf_pkg::POS_CODE_LO: cur_byte = tx_code[7:0];
      tvf_pkg::POS_P1: cur_byte = tx_type;
      tvf_pkg::POS_P2: cur_byte = tx_sub;
      tvf_pkg::POS_P3_HI: cur_byte = tx_p3[15:8];
      tvf_pkg::POS_P3_LO: cur_byte = tx_p3[7:0];
      tvf_pkg::POS_P4_HI: cur_byte = tx_p4[15:8];
      tvf_pkg::POS_P4_LO: cur_byte = tx_p4[7:0];
      default:
      begin
        // time stamp bytes, seconds first
        if (tx_idx >= tvf_pkg::POS_TIME0 && tx_idx < tvf_pkg::POS_PUS)
        begin
          cur_byte = tx_time[8'(47 - 8 * (tx_idx - tvf_pkg::POS_TIME0)) -: 8];
        end
      end
    endcase
  end

  assign fifo_in_valid = (tx_state == tvf_pkg::TVF_TX_SEND);

  // serializer: takes a request, stamps time, pushes bytes under back-pressure
  always_comb
  begin
    next_tx_state = tx_state;
    next_tx_idx = tx_idx;
    next_seq_cnt = seq_cnt;
    next_tx_time = tx_time;
    next_tx_fail = tx_fail;
    next_tx_code = tx_code;
    next_tx_p3 = tx_p3;
    next_tx_p4 = tx_p4;
    next_tx_id = tx_id;
    next_tx_seq = tx_seq;
    next_tx_type = tx_type;
    next_tx_sub = tx_sub;
    case (tx_state)
      tvf_pkg::TVF_TX_IDLE:
      begin
        if (take)
        begin
          next_tx_state = tvf_pkg::TVF_TX_SEND;
          next_tx_idx = '0;
          next_tx_time = spacecraft_elapsed_time;
          next_tx_fail = rq_fail;
          next_tx_code = rq_code;
          next_tx_p3 = rq_p3;
          next_tx_p4 = rq_p4;
          next_tx_id = rq_id;
          next_tx_seq = rq_seq;
          next_tx_type = rq_type;
          next_tx_sub = rq_sub;
        end
      end
      tvf_pkg::TVF_TX_SEND:
      begin
        if (fifo_in_ready)
        begin
          next_tx_idx = tx_idx + 5'h01;
          if (tx_idx == cur_len - 5'h01)
          begin
            next_tx_state = tvf_pkg::TVF_TX_IDLE;
            next_seq_cnt = seq_cnt + 14'h0001;
          end
        end
      end
      default:
      begin
        next_tx_state = tvf_pkg::TVF_TX_IDLE;
      end
    endcase
  end

  // serializer registers
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      tx_state <= tvf_pkg::TVF_TX_IDLE;
      tx_idx <= '0;
      seq_cnt <= tvf_pkg::SEQ_CNT_RESET;
      tx_time <= '0;
      tx_fail <= 1'b0;
      tx_code <= '0;
      tx_p3 <= '0;
      tx_p4 <= '0;
      tx_id <= '0;
      tx_seq <= '0;
      tx_type <= '0;
      tx_sub <= '0;
    end
    else if (ce)
    begin
      tx_state <= next_tx_state;
      tx_idx <= next_tx_idx;
      seq_cnt <= next_seq_cnt;
      tx_time <= next_tx_time;
      tx_fail <= next_tx_fail;
      tx_code <= next_tx_code;
      tx_p3 <= next_tx_p3;
      tx_p4 <= next_tx_p4;
      tx_id <= next_tx_id;
      tx_seq <= next_tx_seq;
      tx_type <= next_tx_type;
      tx_sub <= next_tx_sub;
    end
  end

  // output buffer, last flag travels in the top bit
  tvf_fifo #(
    .WIDTH(tvf_pkg::FIFO_WIDTH),
    .DEPTH(tvf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({tx_idx == cur_len - 5'h01, cur_byte}),
    .out_valid(tm_valid),
    .out_ready(tm_ready),
    .out_data({tm_last, tm_data})
  );
endmodule

// ### tvf_pkg.sv
// tvf_pkg: constants for the telecommand verification report framer
// assumes a single 250 MHz clock domain and byte-wide telemetry output
package tvf_pkg;
  // clock and timeout figures
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned TC_TIMEOUT_S = 2;
  localparam int unsigned TC_TIMEOUT_CYC = TC_TIMEOUT_S * CLK_HZ;

  // fifo shape
  localparam int unsigned FIFO_WIDTH = 9;
  localparam int unsigned FIFO_DEPTH = 16;

  // primary header constants
  localparam logic [7:0] HDR_BYTE0 = 8'h0D;
  localparam logic [3:0] APID_LOW = 4'h1;
  localparam logic [3:0] CAT_ACK = 4'h1;
  localparam logic [1:0] SEQ_FLAGS = 2'h3;
  localparam logic [7:0] LEN_HIGH = 8'h00;

  // data field header constants
  localparam logic [7:0] PUS_BYTE = 8'h40;
  localparam logic [7:0] SVC_VERIF = 8'h01;
  localparam logic [7:0] SUB_SUCCESS = 8'h01;
  localparam logic [7:0] SUB_FAILURE = 8'h02;
  localparam logic [7:0] PAD_BYTE = 8'h00;

  // data field lengths in bytes and whole packet lengths
  localparam logic [7:0] DF_LEN_SUCCESS = 8'h0E;
  localparam logic [7:0] DF_LEN_FAILURE = 8'h16;
  localparam logic [4:0] PKT_LEN_SUCCESS = 5'h14;
  localparam logic [4:0] PKT_LEN_FAILURE = 5'h1C;

  // byte positions inside a report
  localparam logic [4:0] POS_SEQ_HI = 5'h02;
  localparam logic [4:0] POS_SEQ_LO = 5'h03;
  localparam logic [4:0] POS_LEN_HI = 5'h04;
  localparam logic [4:0] POS_LEN_LO = 5'h05;
  localparam logic [4:0] POS_TIME0 = 5'h06;
  localparam logic [4:0] POS_PUS = 5'h0C;
  localparam logic [4:0] POS_SVC = 5'h0D;
  localparam logic [4:0] POS_SUB = 5'h0E;
  localparam logic [4:0] POS_PAD = 5'h0F;
  localparam logic [4:0] POS_ID_HI = 5'h10;
  localparam logic [4:0] POS_ID_LO = 5'h11;
  localparam logic [4:0] POS_SC_HI = 5'h12;
  localparam logic [4:0] POS_SC_LO = 5'h13;
  localparam logic [4:0] POS_CODE_HI = 5'h14;
  localparam logic [4:0] POS_CODE_LO = 5'h15;
  localparam logic [4:0] POS_P1 = 5'h16;
  localparam logic [4:0] POS_P2 = 5'h17;
  localparam logic [4:0] POS_P3_HI = 5'h18;
  localparam logic [4:0] POS_P3_LO = 5'h19;
  localparam logic [4:0] POS_P4_HI = 5'h1A;
  localparam logic [4:0] POS_P4_LO = 5'h1B;

  // failure codes
  localparam logic [15:0] FAIL_INCOMPLETE_TIMEOUT = 16'h0001;
  localparam logic [15:0] FAIL_CRC_MISMATCH = 16'h0002;
  localparam logic [15:0] FAIL_WRONG_PROCESS_ID = 16'h0003;
  localparam logic [15:0] FAIL_INVALID_COMMAND = 16'h0004;
  localparam logic [15:0] FAIL_NOT_EXECUTABLE_NOW = 16'h0005;
  localparam logic [15:0] FAIL_INCONSISTENT_PAYLOAD = 16'h0006;

  // reset values
  localparam logic [13:0] SEQ_CNT_RESET = 14'h0000;

  // receiver and serializer states
  typedef enum logic [1:0] {
    TVF_RX_IDLE = 2'b01,
    TVF_RX_RECV = 2'b10
  } tvf_rx_state_t;

  typedef enum logic [1:0] {
    TVF_TX_IDLE = 2'b01,
    TVF_TX_SEND = 2'b10
  } tvf_tx_state_t;
endpackage

// ### tvf_fifo.sv
// tvf_fifo: synchronous fifo with a registered output stage
// assumes one clock, synchronous active-low reset and a clock enable
`timescale 1ns/1ps
module tvf_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic push;
  logic pop;

  // full and empty come straight from the stored count
  assign in_ready = (count != DEPTH[AW:0]);
  assign push = in_valid && in_ready;
  assign pop = (count != '0) && (!out_valid || out_ready);

  // pointer, count and output stage updates
  always_comb
  begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    next_out_valid = out_valid;
    next_out_data = out_data;
    if (pop)
    begin
      next_out_valid = 1'b1;
      next_out_data = mem[rd_ptr];
    end
    else if (out_ready)
    begin
      next_out_valid = 1'b0;
    end
  end

  // state registers, frozen while ce is low
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (ce)
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      out_valid <= next_out_valid;
      out_data <= next_out_data;
    end
  end

  // storage array, written on push only
  always_ff @(posedge ref_clk)
  begin
    if (ce && push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// ### tvf_framer_assertions.sv
// tvf_framer_assertions: framing and handshake checks on the report stream
// assumes one ref_clk domain; bound onto every tvf_framer instance
`timescale 1ns/1ps
module tvf_framer_assertions #(
  parameter int unsigned TIMEOUT_CYC = tvf_pkg::TC_TIMEOUT_CYC
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tc_end,
  input wire logic [7:0] tm_data,
  input wire logic tm_last,
  input wire logic tm_valid,
  input wire logic tm_ready,
  input wire logic tc_receiving
);
  logic xfer;
  logic [4:0] idx;
  logic [7:0] len;
  logic [5:0] seq_hi;
  logic [13:0] last_seq;
  logic have_prev;
  logic [31:0] rx_cnt;

  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // a byte moves when both sides agree
  assign xfer = ce && tm_valid && tm_ready;

  // byte position, length field, last sequence number and receive time
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      idx <= 5'h00;
      len <= 8'h00;
      seq_hi <= 6'h00;
      last_seq <= 14'h0000;
      have_prev <= 1'b0;
      rx_cnt <= 32'h0000_0000;
    end
    else if (ce)
    begin
      rx_cnt <= tc_receiving ? rx_cnt + 32'h0000_0001 : 32'h0000_0000;
      idx <= xfer ? (tm_last ? 5'h00 : idx + 5'h01) : idx;
      len <= (xfer && idx == 5'h05) ? tm_data : len;
      seq_hi <= (xfer && idx == 5'h02) ? tm_data[5:0] : seq_hi;
      last_seq <= (xfer && idx == 5'h03) ? {seq_hi, tm_data} : last_seq;
      have_prev <= have_prev || (xfer && idx == 5'h03);
    end
  end

  frame_length_a: assert property (xfer && tm_last |-> (idx == 5'h13 && len == 8'h0D) || (idx == 5'h1B && len == 8'h15))
    else $error("report length disagrees with its length field");
  first_byte_a: assert property (xfer && idx == 5'h00 |-> tm_data == 8'h0D)
    else $error("report does not open with the header byte");
  category_byte_a: assert property (xfer && idx == 5'h01 |-> tm_data == 8'h11)
    else $error("category byte wrong");
  seq_flags_a: assert property (xfer && idx == 5'h02 |-> tm_data[7:6] == 2'b11)
    else $error("sequence flag bits not both set");
  seq_step_a: assert property (xfer && idx == 5'h03 && have_prev |-> {seq_hi, tm_data} == last_seq + 14'h0001)
    else $error("report counter did not advance by one");
  service_subtype_a: assert property (xfer && (idx == 5'h0D || idx == 5'h0E)
    |-> tm_data == ((idx == 5'h0D || len == 8'h0D) ? 8'h01 : 8'h02))
    else $error("service or subtype byte wrong");
  code_range_a: assert property (xfer && idx == 5'h14 |-> tm_data == 8'h00)
    else $error("failure code high byte not zero");
  stall_hold_a: assert property (tm_valid && !tm_ready && ce |=> tm_valid && $stable(tm_data) && $stable(tm_last))
    else $error("report byte changed while stalled");
  end_closes_a: assert property (tc_receiving && tc_end && ce |=> !tc_receiving)
    else $error("reception still open after end of command");
  rx_bound_a: assert property (tc_receiving |-> rx_cnt <= TIMEOUT_CYC)
    else $error("reception outlived the timeout");
endmodule

bind tvf_framer tvf_framer_assertions #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
  .tc_end(tc_end), .tm_data(tm_data), .tm_last(tm_last), .tm_valid(tm_valid), .tm_ready(tm_ready),
  .tc_receiving(tc_receiving));

// ### tvf_tc_source.sv
// tvf_tc_source: behavioural data handling computer sending telecommands
// assumes the framer samples on the rising edge; this side moves on the falling edge
`timescale 1ns/1ps
module tvf_tc_source (
  input wire logic ref_clk,
  output logic tc_start,
  output logic tc_byte,
  output logic tc_hdr_valid,
  output logic [15:0] tc_packet_id,
  output logic [15:0] tc_seq_ctrl,
  output logic [15:0] tc_expected_bytes,
  output logic [7:0] tc_type,
  output logic [7:0] tc_subtype,
  output logic tc_ack,
  output logic tc_end,
  output logic [15:0] tc_crc_rx,
  output logic [15:0] tc_crc_calc,
  output logic tc_wrong_id,
  output logic tc_invalid,
  output logic tc_not_exec,
  output logic tc_bad_payload
);
  // idle lines at time zero
  initial
  begin
    {tc_start, tc_byte, tc_hdr_valid, tc_end} = 4'h0;
    {tc_packet_id, tc_seq_ctrl, tc_expected_bytes, tc_type, tc_subtype, tc_ack} = '0;
    {tc_crc_rx, tc_crc_calc, tc_wrong_id, tc_invalid, tc_not_exec, tc_bad_payload} = '0;
  end

  // one command; stale fields inverted
  task send(input logic [15:0] id, sc, nexp, crx, ccalc, input logic [7:0] ty, st, input logic ack,
    input logic [3:0] flags, input int nbytes, input int gap, input bit finish);
    @(negedge ref_clk) tc_start = 1'b1;
    @(negedge ref_clk) tc_start = 1'b0;
    tc_hdr_valid = 1'b1;
    {tc_packet_id, tc_seq_ctrl, tc_expected_bytes, tc_type, tc_subtype, tc_ack} = {id, sc, nexp, ty, st, ack};
    @(negedge ref_clk) tc_hdr_valid = 1'b0;
    {tc_packet_id, tc_seq_ctrl, tc_expected_bytes, tc_type, tc_subtype, tc_ack} = ~{id, sc, nexp, ty, st, ack};
    tc_byte = 1'b1;
    repeat (nbytes) @(negedge ref_clk);
    tc_byte = 1'b0;
    repeat (gap) @(negedge ref_clk);
    if (finish)
    begin
      tc_end = 1'b1;
      {tc_crc_rx, tc_crc_calc, tc_wrong_id, tc_invalid, tc_not_exec, tc_bad_payload} = {crx, ccalc, flags};
      @(negedge ref_clk) tc_end = 1'b0;
      {tc_crc_rx, tc_crc_calc, tc_wrong_id, tc_invalid, tc_not_exec, tc_bad_payload} = ~{crx, ccalc, flags};
    end
  endtask
endmodule

// ### test_tc_verification_report_framer.sv
// test_tc_verification_report_framer: self-checking bench for the report framer
// assumes tvf_tc_source feeds commands; bench owns reset, clock enable and tm_ready
`timescale 1ns/1ps
module test_tc_verification_report_framer;
  localparam int unsigned TMO = 50;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic tm_ready = 1'b1;
  logic [47:0] spacecraft_elapsed_time = 48'h1234_5678_9abc;
  logic tc_start, tc_byte, tc_hdr_valid, tc_ack, tc_end, tc_wrong_id, tc_invalid, tc_not_exec, tc_bad_payload;
  logic [15:0] tc_packet_id, tc_seq_ctrl, tc_expected_bytes, tc_crc_rx, tc_crc_calc;
  logic [7:0] tc_type, tc_subtype, tm_data;
  logic tm_last, tm_valid, tc_receiving, report_overrun;
  logic [13:0] exp_seq = 14'h0000;
  logic [7:0] got [$];
  logic [7:0] exp [$];
  int miscompares = 0;
  int n_tests = 0;
  logic ovr = 1'b0;

  // free running clock
  always #2 ref_clk = ~ref_clk;

  // overrun seen
  always @(negedge ref_clk) ovr |= report_overrun;

  tvf_tc_source tc_u (.ref_clk(ref_clk), .tc_start(tc_start), .tc_byte(tc_byte), .tc_hdr_valid(tc_hdr_valid),
    .tc_packet_id(tc_packet_id), .tc_seq_ctrl(tc_seq_ctrl), .tc_expected_bytes(tc_expected_bytes),
    .tc_type(tc_type), .tc_subtype(tc_subtype), .tc_ack(tc_ack), .tc_end(tc_end), .tc_crc_rx(tc_crc_rx),
    .tc_crc_calc(tc_crc_calc), .tc_wrong_id(tc_wrong_id), .tc_invalid(tc_invalid), .tc_not_exec(tc_not_exec),
    .tc_bad_payload(tc_bad_payload));

  tvf_framer #(.TIMEOUT_CYC(TMO)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .tc_start(tc_start),
    .tc_byte(tc_byte), .tc_hdr_valid(tc_hdr_valid), .tc_packet_id(tc_packet_id), .tc_seq_ctrl(tc_seq_ctrl),
    .tc_expected_bytes(tc_expected_bytes), .tc_type(tc_type), .tc_subtype(tc_subtype), .tc_ack(tc_ack),
    .tc_end(tc_end), .tc_crc_rx(tc_crc_rx), .tc_crc_calc(tc_crc_calc), .tc_wrong_id(tc_wrong_id),
    .tc_invalid(tc_invalid), .tc_not_exec(tc_not_exec), .tc_bad_payload(tc_bad_payload),
    .spacecraft_elapsed_time(spacecraft_elapsed_time), .tm_data(tm_data), .tm_last(tm_last),
    .tm_valid(tm_valid), .tm_ready(tm_ready), .tc_receiving(tc_receiving), .report_overrun(report_overrun));

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] expv, input string what);
    n_tests++;
    if (seen !== expv)
    begin
      miscompares++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, expv);
    end
  endtask

  // take one report; a stall fills the fifo
  task automatic collect(input bit stall);
    got.delete();
    for (int k = 0; k < 400; k++)
    begin
      @(negedge ref_clk);
      tm_ready = !stall || (k > 40 && k[0]);
      if (tm_valid === 1'b1 && tm_ready)
      begin
        got.push_back(tm_data);
        if (tm_last === 1'b1)
          break;
      end
    end
  endtask

  // build the expected bytes, collect and compare
  task automatic expect_report(input bit fail, input logic [15:0] code, id, sc, p3, p4,
    input logic [7:0] ty, st, input bit stall);
    exp = '{8'h0D, 8'h11, {2'b11, exp_seq[13:8]}, exp_seq[7:0], 8'h00, fail ? 8'h15 : 8'h0D};
    for (int i = 5; i >= 0; i--)
      exp.push_back(spacecraft_elapsed_time[i*8 +: 8]);
    exp = {exp, 8'h40, 8'h01, fail ? 8'h02 : 8'h01, 8'h00, id[15:8], id[7:0], sc[15:8], sc[7:0]};
    if (fail)
      exp = {exp, code[15:8], code[7:0], ty, st, p3[15:8], p3[7:0], p4[15:8], p4[7:0]};
    collect(stall);
    check(16'(got.size()), 16'(exp.size()), "report length");
    for (int i = 0; i < exp.size(); i++)
      check({8'h00, got[i]}, {8'h00, exp[i]}, "report byte");
    exp_seq++;
  endtask

  // valid command with acknowledge set
  task automatic t_success();
    tc_u.send(16'h1D1C, 16'hC0A5, 16'h000A, 16'h1111, 16'h1111, 8'h11, 8'h01, 1'b1, 4'h0, 4, 6, 1'b1);
    expect_report(1'b0, 16'h0000, 16'h1D1C, 16'hC0A5, 16'h0000, 16'h0000, 8'h11, 8'h01, 1'b0);
  endtask

  // valid command without acknowledge gives nothing
  task automatic t_no_ack();
    tc_u.send(16'h1D1C, 16'hC0A6, 16'h0008, 16'h2222, 16'h2222, 8'h11, 8'h02, 1'b0, 4'h0, 2, 0, 1'b1);
    tm_ready = 1'b0;
    repeat (30) @(negedge ref_clk);
    check({15'h0000, tm_valid}, 16'h0000, "report without acknowledge");
  endtask

  // every failure cause except the timeout, with all lower priority causes also present
  task automatic t_failures();
    logic [15:0] crx;
    for (int c = 2; c <= 6; c++)
    begin
      crx = (c == 2) ? 16'hbeef : 16'h5a5a;
      tc_u.send(16'h1D1C, 16'hC100 | 16'(c), 16'h0010, crx, 16'h5a5a, 8'h20 + 8'(c), 8'h03, 1'b1,
        {c <= 3, c <= 4, c <= 5, 1'b1}, 5, 0, 1'b1);
      expect_report(1'b1, 16'(c), 16'h1D1C, 16'hC100 | 16'(c), (c == 2) ? crx : 16'h0000,
        (c == 2) ? 16'h5a5a : 16'h0000, 8'h20 + 8'(c), 8'h03, c == 4);
    end
  endtask

  // command that never ends: incomplete timeout report
  task automatic t_timeout();
    tc_u.send(16'h1D1C, 16'hC2C3, 16'h0040, 16'h0000, 16'h0000, 8'h06, 8'h07, 1'b1, 4'h0, 3, 0, 1'b0);
    expect_report(1'b1, 16'h0001, 16'h1D1C, 16'hC2C3, 16'h0040, 16'h0003, 8'h06, 8'h07, 1'b0);
  endtask

  // counts and verdict
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    t_success();
    t_no_ack();
    t_success();
    t_failures();
    t_timeout();
    check({15'h0000, ovr}, 16'h0000, "report overrun");
    report_and_stop();
  end

  // hang guard
  initial
  begin
    #(4 * 20000);
    miscompares++;
    report_and_stop();
  end
endmodule
